/* File: dv/ios_exec_tb.sv */
// Self-checking bench of the execution slice: fixed table, then random stream.
// Assumes ios_pkg and ios_file_model are compiled before it.
`timescale 1ns/100ps
`include "ios_cfg.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end

module ios_exec_tb
  import ios_pkg::*;
;
  typedef struct {logic [7:0] w; logic c; logic z; logic [14:0] pc; logic [6:0] a;
    logic [7:0] f; logic t;} ios_note_type;
  logic ref_clk, rst_b, instr_valid, instr_dest, instr_ready_q, instr_done_q, no_op;
  ios_op_type instr_op;
  logic [6:0] instr_file_addr, latch, wr_a, prev_a;
  logic [10:0] instr_literal;
  logic [7:0] rd_d, work_q, wr_d, w_e;
  logic carry_q, zero_q, wr_en, c_e, z_e;
  logic [14:0] program_counter_q, pc_e;
  logic [7:0] f_e [0:127];
  ios_note_type notes[$];
  int error_cnt = 0;
  int samples_checked = 0;

  ios_exec u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_file_addr(instr_file_addr), .instr_dest(instr_dest),
    .instr_literal(instr_literal), .file_rd_data(rd_d),
    .program_counter_upper_latch(latch), .instr_ready_q(instr_ready_q),
    .instr_done_q(instr_done_q), .no_operation_q(no_op), .work_q(work_q),
    .carry_q(carry_q), .zero_q(zero_q), .program_counter_q(program_counter_q),
    .file_wr_en_q(wr_en), .file_wr_addr_q(wr_a), .file_wr_data_q(wr_d));
  ios_file_model u_mem (.ref_clk(ref_clk), .rd_addr(instr_file_addr), .rd_data(rd_d),
    .wr_en(wr_en), .wr_addr(wr_a), .wr_data(wr_d));

  // 25 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Works out the result, notes it, then holds the request until taken;
  // valid stays up between calls so no signal is driven twice per step
  task automatic issue(ios_op_type op, logic [6:0] a, logic d, logic [10:0] k,
    logic [6:0] l);
    logic [7:0] r;
    logic fop;
    int n;
    fop = op inside {IOS_INC_SKIP, IOS_INC, IOS_OR_FILE, IOS_SHL};
    r = (op == IOS_OR_FILE) ? (w_e | f_e[a]) :
      (op == IOS_SHL) ? {f_e[a][6:0], 1'b0} : f_e[a] + 8'h01;
    if (op == IOS_SHL)
      c_e = f_e[a][7];
    if (op inside {IOS_INC, IOS_OR_FILE, IOS_SHL})
      z_e = (r == 8'h00);
    if (op == IOS_OR_LIT)
      w_e = w_e | k[7:0];
    if (op == IOS_OR_LIT)
      z_e = (w_e == 8'h00);
    if (fop && d)
      f_e[a] = r;
    else if (fop)
      w_e = r;
    pc_e = (op == IOS_BRANCH) ? {l[6:3], k} :
      pc_e + 15'h0001 + {14'h0000, (op == IOS_INC_SKIP) && (r == 8'h00)};
    // Two-cycle ops are the branch and a skip whose sum is zero
    notes.push_back('{w_e, c_e, z_e, pc_e, a, f_e[a],
      (op == IOS_BRANCH) || ((op == IOS_INC_SKIP) && (r == 8'h00))});
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_file_addr <= a;
    instr_dest <= d;
    instr_literal <= k;
    latch <= l;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (instr_ready_q !== 1'b1 && n < 20);
    @(posedge ref_clk);
  endtask

  task automatic drain(string name);
    instr_valid <= 1'b0;
    repeat (5) @(posedge ref_clk);
    $display("test %s done", name);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Monitor: registers at the done pulse, file byte one cycle later once landed
  initial
  begin
    logic pend;
    logic prev_nop;
    ios_note_type n;
    pend = 1'b0;
    prev_nop = 1'b0;
    forever
    begin
      @(negedge ref_clk);
      if (pend)
        `CHK(u_mem.mem[n.a], n.f)
      pend = (instr_done_q === 1'b1);
      if (pend)
      begin
        `CHK(notes.size() != 0, 1'b1)
        n = notes.pop_front();
        `CHK(work_q, n.w)
        `CHK(carry_q, n.c)
        `CHK(zero_q, n.z)
        `CHK(program_counter_q, n.pc)
        `CHK(prev_nop, n.t)
        `CHK({no_op, instr_ready_q}, 2'b01)
      end
      // Squashed-cycle level seen one cycle before the done pulse
      prev_nop = (no_op === 1'b1);
    end
  end

  // Watchdog, far beyond the under 200 cycles the tests need
  initial
  begin
    repeat (4000) @(posedge ref_clk);
    error_cnt++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [6:0] a;
    void'($urandom(32'ha907ae15));
    rst_b = 1'b0;
    instr_valid = 1'b0;
    instr_op = IOS_NONE;
    instr_file_addr = 7'h00;
    instr_dest = 1'b0;
    instr_literal = 11'h000;
    latch = 7'h00;
    {w_e, c_e, z_e, pc_e, prev_a} = '0;
    for (int i = 0; i < 128; i++)
      f_e[i] = 8'($urandom);
    {f_e[1], f_e[2], f_e[3], f_e[5]} = {8'hff, 8'h80, 8'h00, 8'hff};
    for (int i = 0; i < 128; i++)
      u_mem.mem[i] = f_e[i];
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    `CHK({work_q, program_counter_q, instr_ready_q}, {8'h00, 15'h0000, 1'b1})
    @(posedge ref_clk);
    // Skips, zero results, carry out, branch with top literal, ignored upper bits
    issue(IOS_INC_SKIP, 7'h01, 1'b1, 11'h000, 7'h00);
    issue(IOS_INC_SKIP, 7'h05, 1'b0, 11'h000, 7'h00);
    issue(IOS_OR_LIT, 7'h00, 1'b0, 11'h000, 7'h00);
    issue(IOS_OR_FILE, 7'h03, 1'b1, 11'h000, 7'h00);
    issue(IOS_SHL, 7'h02, 1'b1, 11'h000, 7'h00);
    issue(IOS_INC_SKIP, 7'h01, 1'b0, 11'h000, 7'h00);
    issue(IOS_INC, 7'h03, 1'b0, 11'h000, 7'h00);
    issue(IOS_BRANCH, 7'h00, 1'b0, 11'h7ff, 7'h5a);
    issue(IOS_NONE, 7'h00, 1'b0, 11'h000, 7'h00);
    issue(IOS_OR_LIT, 7'h00, 1'b0, 11'h7c3, 7'h00);
    drain("table");
    // Back-to-back random stream; never rereads the byte just written
    for (int i = 0; i < 80; i++)
    begin
      a = 7'($urandom_range(0, 127));
      if (a == prev_a)
        a = a + 7'h01;
      prev_a = a;
      issue(ios_op_type'($urandom_range(0, 7)), a, 1'($urandom), 11'($urandom),
        7'($urandom));
    end
    drain("random");
    `CHK(notes.size(), 0)
    tally_and_finish();
  end
endmodule

/* File: dv/ios_file_model.sv */
// Data file register model standing beside the execution slice.
// Assumes the bench preloads mem; reads are combinational.
`timescale 1ns/100ps
`include "ios_cfg.svh"

module ios_file_model
  import ios_pkg::*;
(
  ref_clk,
  rd_addr,
  rd_data,
  wr_en,
  wr_addr,
  wr_data
);
  input wire logic ref_clk;
  input wire logic [`IOS_ADDR_W-1:0] rd_addr;
  output logic [`IOS_DATA_W-1:0] rd_data;
  input wire logic wr_en;
  input wire logic [`IOS_ADDR_W-1:0] wr_addr;
  input wire logic [`IOS_DATA_W-1:0] wr_data;

  logic [`IOS_DATA_W-1:0] mem [0:127];

  // Same-cycle read of the addressed register, all 128 places
  assign rd_data = mem[rd_addr];

  // Write lands on the edge that samples the pulse, so a reader in
  // that same cycle still sees the old byte
  always @(posedge ref_clk)
  begin
    if (wr_en === 1'b1)
      mem[wr_addr] <= wr_data;
  end
endmodule

/* File: shared/ios_cfg.svh */
// Constants of the increment, OR, shift and branch execution slice.
// Assumes inclusion by bare name from the package and the design files.
`ifndef IOS_CFG_SVH
`define IOS_CFG_SVH

// Datapath widths
`define IOS_DATA_W 8
`define IOS_ADDR_W 7
`define IOS_PC_W 15
`define IOS_LIT_W 11
`define IOS_LATCH_W 7

// Field positions
`define IOS_DATA_MSB 7
`define IOS_PC_LOW_MSB 10
`define IOS_LATCH_SEL_MSB 6
`define IOS_LATCH_SEL_LSB 3
`define IOS_LIT8_MSB 7
`define IOS_ST_NOP_BIT 1

// Operation codes
`define IOS_OP_NONE 3'h0
`define IOS_OP_INC_SKIP 3'h1
`define IOS_OP_INC 3'h2
`define IOS_OP_OR_LIT 3'h3
`define IOS_OP_OR_FILE 3'h4
`define IOS_OP_SHL 3'h5
`define IOS_OP_BRANCH 3'h6

// Destination selector values
`define IOS_DEST_WORK 1'h0
`define IOS_DEST_FILE 1'h1

// Reset values and constants
`define IOS_PC_RESET 15'h0000
`define IOS_WORK_RESET 8'h00
`define IOS_ADDR_RESET 7'h00
`define IOS_BYTE_ZERO 8'h00
`define IOS_BYTE_ONE 8'h01
`define IOS_PC_STEP 15'h0001

`endif

/* File: shared/ios_pkg.sv */
// Types of the increment, OR, shift and branch execution slice.
// Assumes ios_cfg.svh is on the include path.
`include "ios_cfg.svh"

package ios_pkg;

  // Operation selected by the decoder outside this slice
  typedef enum logic [2:0] {
    IOS_NONE = `IOS_OP_NONE,
    IOS_INC_SKIP = `IOS_OP_INC_SKIP,
    IOS_INC = `IOS_OP_INC,
    IOS_OR_LIT = `IOS_OP_OR_LIT,
    IOS_OR_FILE = `IOS_OP_OR_FILE,
    IOS_SHL = `IOS_OP_SHL,
    IOS_BRANCH = `IOS_OP_BRANCH
  } ios_op_type;

  // Execution phase, one-hot
  typedef enum logic [1:0] {
    IOS_ST_RUN = 2'b01,
    IOS_ST_NOP = 2'b10
  } ios_state_type;

  // Whole state of the slice
  typedef struct packed {
    ios_state_type state;
    logic ready;
    logic done;
    logic nop_pc_step;
    logic [`IOS_DATA_W-1:0] work;
    logic carry;
    logic zero;
    logic [`IOS_PC_W-1:0] pc;
    logic wr_en;
    logic [`IOS_ADDR_W-1:0] wr_addr;
    logic [`IOS_DATA_W-1:0] wr_data;
  } ios_regs_type;

  // True for operations whose result goes where the destination bit says
  function automatic logic ios_uses_dest(input ios_op_type op);
    return (op == IOS_INC_SKIP) || (op == IOS_INC) || (op == IOS_OR_FILE) || (op == IOS_SHL);
  endfunction

  // True when an 8-bit value is zero
  function automatic logic ios_is_zero(input logic [`IOS_DATA_W-1:0] v);
    return v == `IOS_BYTE_ZERO;
  endfunction

endpackage

/* File: src/ios_alu.sv */
// Combinational result unit of the execution slice.
// Assumes operands are stable for the whole cycle in which they are used.
`timescale 1ns/100ps
`include "ios_cfg.svh"

module ios_alu
  import ios_pkg::*;
#(
  parameter int DATA_W = `IOS_DATA_W
)
(
  input wire ios_op_type op,
  input wire logic [DATA_W-1:0] work,
  input wire logic [DATA_W-1:0] file_data,
  input wire logic [DATA_W-1:0] literal,
  output logic [DATA_W-1:0] result,
  output logic carry_out,
  output logic carry_we,
  output logic zero_we
);

  ////////////////////////////////////////////////////////////////////////////
  // Result and flag enables per operation
  always_comb
  begin
    result = work;
    carry_out = 1'b0;
    carry_we = 1'b0;
    zero_we = 1'b0;
    case (op)
      IOS_INC_SKIP:
      begin
        result = file_data + DATA_W'(`IOS_BYTE_ONE); // Flags untouched
      end
      IOS_INC:
      begin
        result = file_data + DATA_W'(`IOS_BYTE_ONE);
        zero_we = 1'b1;
      end
      IOS_OR_LIT:
      begin
        result = work | literal;
        zero_we = 1'b1;
      end
      IOS_OR_FILE:
      begin
        result = work | file_data;
        zero_we = 1'b1;
      end
      IOS_SHL:
      begin
        result = {file_data[DATA_W-2:0], 1'b0}; // Zero enters the low bit
        carry_out = file_data[DATA_W-1];
        carry_we = 1'b1;
        zero_we = 1'b1;
      end
      default:
      begin
        result = work;
      end
    endcase
  end

endmodule

/* File: src/ios_exec.sv */
// Execution slice of an 8-bit core: increment with skip, increment,
// OR with literal or file, logical left shift and absolute branch.
// Assumes the file register array outside returns file_rd_data for
// instr_file_addr in the same cycle and applies file_wr_* on the next edge.
//
// Operation
// - Increment-and-skip adds one, writes destination, leaves every flag alone.
// - Zero increment-and-skip sum replaces next instruction by no-operation; two cycles.
// - Branch loads 11-bit literal into program counter bits ten to zero.
// - Branch fills counter bits fourteen to eleven from upper latch bits six to three.
// - Branch is always taken and takes two cycles.
// - OR-with-literal ORs work with 8-bit literal into work; zero flag updated.
// - Plain increment adds one, writes destination, updates zero flag, never skips.
// - OR-with-file ORs work with file, writes destination, updates zero flag.
// - Left shift: bit seven to carry, bits shift up, zero enters bit zero.
// - Destination bit 0 writes work register; 1 writes the addressed file register.
// - File operand is a 7-bit address; destination selector is one bit.
`timescale 1ns/100ps
`include "ios_cfg.svh"

module ios_exec
  import ios_pkg::*;
(
  ref_clk,
  rst_b,
  instr_valid,
  instr_op,
  instr_file_addr,
  instr_dest,
  instr_literal,
  file_rd_data,
  program_counter_upper_latch,
  instr_ready_q,
  instr_done_q,
  no_operation_q,
  work_q,
  carry_q,
  zero_q,
  program_counter_q,
  file_wr_en_q,
  file_wr_addr_q,
  file_wr_data_q
);
  input wire logic ref_clk;
  input wire logic rst_b;
  input wire logic instr_valid;
  input wire ios_op_type instr_op;
  input wire logic [`IOS_ADDR_W-1:0] instr_file_addr;
  input wire logic instr_dest;
  input wire logic [`IOS_LIT_W-1:0] instr_literal;
  input wire logic [`IOS_DATA_W-1:0] file_rd_data;
  input wire logic [`IOS_LATCH_W-1:0] program_counter_upper_latch;
  output logic instr_ready_q;
  output logic instr_done_q;
  output logic no_operation_q;
  output logic [`IOS_DATA_W-1:0] work_q;
  output logic carry_q;
  output logic zero_q;
  output logic [`IOS_PC_W-1:0] program_counter_q;
  output logic file_wr_en_q;
  output logic [`IOS_ADDR_W-1:0] file_wr_addr_q;
  output logic [`IOS_DATA_W-1:0] file_wr_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // Reset image of the state
  localparam ios_regs_type RESET_VAL = '{
    state: IOS_ST_RUN,
    ready: 1'b1,
    done: 1'b0,
    nop_pc_step: 1'b0,
    work: `IOS_WORK_RESET,
    carry: 1'b0,
    zero: 1'b0,
    pc: `IOS_PC_RESET,
    wr_en: 1'b0,
    wr_addr: `IOS_ADDR_RESET,
    wr_data: `IOS_BYTE_ZERO
  };

  ios_regs_type r_q;
  ios_regs_type r_d;
  logic accept;
  logic [`IOS_DATA_W-1:0] lit8;
  logic [`IOS_PC_W-1:0] branch_target;
  logic [`IOS_DATA_W-1:0] alu_result;
  logic alu_carry;
  logic alu_carry_we;
  logic alu_zero_we;
  logic shl_carry_in;

  ////////////////////////////////////////////////////////////////////////////
  // Operand preparation
  assign accept = instr_valid && r_q.ready; // Requests are ignored in the no-operation cycle
  assign lit8 = instr_literal[`IOS_LIT8_MSB:0];
  // Target is latch bits six to three over the 11-bit literal
  assign branch_target = {
    program_counter_upper_latch[`IOS_LATCH_SEL_MSB:`IOS_LATCH_SEL_LSB],
    instr_literal[`IOS_PC_LOW_MSB:0]
  };
  assign shl_carry_in = file_rd_data[`IOS_DATA_MSB];

  // Shared result unit
  ios_alu #(
    .DATA_W(`IOS_DATA_W)
  ) u_alu (
    .op(instr_op),
    .work(r_q.work),
    .file_data(file_rd_data),
    .literal(lit8),
    .result(alu_result),
    .carry_out(alu_carry),
    .carry_we(alu_carry_we),
    .zero_we(alu_zero_we)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    r_d = r_q;
    r_d.wr_en = 1'b0;
    r_d.done = 1'b0;
    case (r_q.state)
      IOS_ST_RUN:
      begin
        if (accept)
        begin
          r_d.pc = r_q.pc + `IOS_PC_STEP;
          r_d.done = 1'b1; // One cycle by default
          // Route the result by the destination bit
          if (ios_uses_dest(instr_op) && (instr_dest == `IOS_DEST_FILE))
          begin
            r_d.wr_en = 1'b1;
            r_d.wr_addr = instr_file_addr;
            r_d.wr_data = alu_result;
          end
          else if (ios_uses_dest(instr_op) || (instr_op == IOS_OR_LIT))
          begin
            r_d.work = alu_result;
          end
          // Zero flag follows the 8-bit result
          if (alu_zero_we)
          begin
            r_d.zero = ios_is_zero(alu_result);
          end
          if (alu_carry_we)
          begin
            r_d.carry = alu_carry;
          end
          // Zero sum squashes the next instruction
          if ((instr_op == IOS_INC_SKIP) && ios_is_zero(alu_result))
          begin
            r_d.state = IOS_ST_NOP;
            r_d.ready = 1'b0;
            r_d.done = 1'b0;
            r_d.nop_pc_step = 1'b1;
          end
          // Branch is unconditional and costs a second cycle
          if (instr_op == IOS_BRANCH)
          begin
            r_d.pc = branch_target;
            r_d.state = IOS_ST_NOP;
            r_d.ready = 1'b0;
            r_d.done = 1'b0;
            r_d.nop_pc_step = 1'b0;
          end
        end
      end
      IOS_ST_NOP:
      begin
        // Skipped word still advances the counter; a branch already landed
        if (r_q.nop_pc_step)
        begin
          r_d.pc = r_q.pc + `IOS_PC_STEP;
        end
        r_d.state = IOS_ST_RUN;
        r_d.ready = 1'b1;
        r_d.done = 1'b1;
        r_d.nop_pc_step = 1'b0;
      end
      default:
      begin
        // Stray code recovers to a clean run phase
        r_d.state = IOS_ST_RUN;
        r_d.ready = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register, synchronous reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      r_q <= RESET_VAL;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state flops
  assign instr_ready_q = r_q.ready;
  assign instr_done_q = r_q.done;
  assign no_operation_q = r_q.state[`IOS_ST_NOP_BIT]; // One-hot bit, no decode on the pin
  assign work_q = r_q.work;
  assign carry_q = r_q.carry;
  assign zero_q = r_q.zero;
  assign program_counter_q = r_q.pc;
  assign file_wr_en_q = r_q.wr_en;
  assign file_wr_addr_q = r_q.wr_addr;
  assign file_wr_data_q = r_q.wr_data;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  logic take_skip;
  logic take_branch;
  logic take_single;
  assign take_skip = accept && (instr_op == IOS_INC_SKIP) && ios_is_zero(alu_result);
  assign take_branch = accept && (instr_op == IOS_BRANCH);
  assign take_single = accept && !take_skip && !take_branch;

  // One stalled cycle then ready again
  sequence s_two_cycle;
    !instr_ready_q && no_operation_q ##1 instr_ready_q && instr_done_q;
  endsequence

  sequence s_one_cycle;
    instr_ready_q && instr_done_q && !no_operation_q;
  endsequence

  a_skip_flags_hold: assert property (
    accept && (instr_op == IOS_INC_SKIP) |=> $stable(zero_q) && $stable(carry_q))
    else $error("increment-and-skip changed a flag");

  a_skip_two_cycle: assert property (
    take_skip |=> s_two_cycle ##0 program_counter_q == $past(program_counter_q, 2) + 15'h0002)
    else $error("skip did not take two cycles or advance by two");

  a_branch_target: assert property (
    take_branch |=> program_counter_q == $past(branch_target))
    else $error("branch target wrong");

  a_branch_two_cycle: assert property (
    take_branch |=> s_two_cycle ##0 $stable(program_counter_q))
    else $error("branch did not take two cycles");

  a_or_lit_result: assert property (
    accept && (instr_op == IOS_OR_LIT)
    |=> work_q == ($past(work_q) | $past(lit8)) && zero_q == (work_q == 8'h00))
    else $error("OR with literal result or zero flag wrong");

  a_inc_to_file: assert property (
    accept && (instr_op == IOS_INC) && instr_dest
    |=> file_wr_en_q && file_wr_data_q == $past(file_rd_data) + 8'h01 && $stable(work_q))
    else $error("increment to file wrong");

  a_or_file_work: assert property (
    accept && (instr_op == IOS_OR_FILE) && !instr_dest
    |=> !file_wr_en_q && work_q == ($past(work_q) | $past(file_rd_data)))
    else $error("OR with file into work wrong");

  a_shift_carry: assert property (
    accept && (instr_op == IOS_SHL) && !instr_dest
    |=> carry_q == $past(shl_carry_in) && work_q == {$past(file_rd_data[6:0]), 1'b0})
    else $error("left shift result or carry wrong");

  a_write_addr: assert property (
    accept && ios_uses_dest(instr_op) && instr_dest
    |=> file_wr_addr_q == $past(instr_file_addr))
    else $error("file write address wrong");

  a_single_cycle: assert property (
    take_single |=> s_one_cycle)
    else $error("single-cycle instruction stalled");

  // A non-zero sum must not cost the following instruction a cycle
  a_skip_no_stall: assert property (
    accept && (instr_op == IOS_INC_SKIP) && !take_skip |=> s_one_cycle)
    else $error("non-zero skip sum stalled");

  a_branch_flags_hold: assert property (
    take_branch |=> $stable(zero_q) && $stable(carry_q) && $stable(work_q))
    else $error("branch changed a flag or the work register");

  a_inc_zero_flag: assert property (
    accept && (instr_op == IOS_INC)
    |=> zero_q == (($past(file_rd_data) + 8'h01) == 8'h00))
    else $error("increment zero flag wrong");

  a_or_file_dest: assert property (
    accept && (instr_op == IOS_OR_FILE) && instr_dest
    |=> file_wr_en_q && $stable(work_q)
    && file_wr_data_q == ($past(work_q) | $past(file_rd_data)))
    else $error("OR with file into file wrong");

endmodule
